// file: pkg/cfw_pkg.sv
// Package with configuration fuse word layout and decoded setting types
package cfw_pkg;
    localparam int WORD_W = 14;
    localparam logic [13:0] ERASED_WORD = 14'h3FFF;
    // Unimplemented positions 12 and 5..4 read as one
    localparam logic [13:0] UNIMPL_MASK = 14'h1030;
    localparam int BIT_PMP = 13;
    localparam int BIT_DMP = 8;
    localparam int BIT_LVP = 7;
    localparam int BIT_BOR = 6;
    localparam int BIT_POWERUP_TIMER = 3;
    localparam int BIT_WDT = 2;
    localparam int BIT_OSC_HI = 1;
    localparam int BIT_OSC_LO = 0;

    typedef enum logic [3:0] {
        CFW_LOW_POWER_CRYSTAL = 4'h1,
        CFW_STANDARD_CRYSTAL = 4'h2,
        CFW_HIGH_SPEED_CRYSTAL = 4'h4,
        CFW_RESISTOR_CAPACITOR_OSC = 4'h8
    } cfw_osc_t;

    localparam logic [1:0] OSC_RC = 2'h3;
    localparam logic [1:0] OSC_HS = 2'h2;
    localparam logic [1:0] OSC_XT = 2'h1;
    localparam logic [1:0] OSC_LP = 2'h0;

    typedef struct packed {
        logic low_voltage_prog_enable;
        logic brownout_reset_en;
        logic watchdog_timer_en;
        logic powerup_timer_en;
        logic data_memory_protect_on;
        logic program_memory_protect_on;
        cfw_osc_t osc_mode;
    } cfw_settings_t;

    typedef struct packed {
        logic wr;
        logic [13:0] data;
    } cfw_prog_t;
endpackage

// file: design/cfw_fuse_store.sv
// Fuse word storage cell array: bits can only be programmed from one to zero
`timescale 1ns/1ps
module cfw_fuse_store (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic prog_wr,
    input wire logic [13:0] prog_data,
    input wire logic erase,
    output logic [13:0] word_q
);
    logic [13:0] word_r;
    logic [13:0] word_nxt;

    always_comb begin
        word_nxt = word_r;
        if (erase) begin
            word_nxt = cfw_pkg::ERASED_WORD;
        end else if (prog_wr) begin
            // Programming can clear bits only; raising needs an erase
            word_nxt = word_r & prog_data;
        end
    end

    // Erased state stands after reset; a real fuse would keep contents
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            word_r <= cfw_pkg::ERASED_WORD;
        end else if (clk_en) begin
            word_r <= word_nxt;
        end
    end

    assign word_q = word_r;

    program_only_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && prog_wr && !erase |=> (word_r & ~$past(word_r)) == 14'h0000)
        else $error("programming raised a fuse bit");
    erase_all_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && erase |=> word_r == cfw_pkg::ERASED_WORD)
        else $error("erase did not restore erased word");
endmodule

// file: design/cfw_decoder.sv
// Configuration fuse word register and decoder of device settings
`timescale 1ns/1ps
module cfw_decoder (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire cfw_pkg::cfw_prog_t prog,
    input wire logic chip_erase,
    input wire logic bulk_erase_data_req,
    input wire logic high_voltage_entry,
    input wire logic shared_port_pin_three_in,
    input wire logic port_pin_three_out,
    input wire logic port_pin_three_oe,
    input wire logic mem_wr_req,
    input wire logic [13:0] mem_rd_raw,
    output logic [13:0] config_rd_data,
    output cfw_pkg::cfw_settings_t settings,
    output logic prog_mode,
    output logic pin_three_to_port,
    output logic shared_port_pin_three_out,
    output logic shared_port_pin_three_oe,
    output logic bulk_erase_data_go,
    output logic mem_wr_go,
    output logic [13:0] mem_rd_data
);
    logic [13:0] fuse_q;
    logic [13:0] word_view;
    cfw_pkg::cfw_settings_t set_nxt;
    cfw_pkg::cfw_settings_t set_r;
    logic [13:0] rd_nxt;
    logic [13:0] rd_r;
    logic [13:0] mrd_nxt;
    logic [13:0] mrd_r;
    logic protect_any;

    // Config word stays programmable under code protection
    cfw_fuse_store u_store (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .prog_wr(prog.wr),
        .prog_data(prog.data),
        .erase(chip_erase),
        .word_q(fuse_q)
    );

    function automatic cfw_pkg::cfw_osc_t osc_decode(input logic [1:0] sel);
        cfw_pkg::cfw_osc_t m;
        m = cfw_pkg::CFW_RESISTOR_CAPACITOR_OSC;
        case (sel)
            cfw_pkg::OSC_RC: m = cfw_pkg::CFW_RESISTOR_CAPACITOR_OSC;
            cfw_pkg::OSC_HS: m = cfw_pkg::CFW_HIGH_SPEED_CRYSTAL;
            cfw_pkg::OSC_XT: m = cfw_pkg::CFW_STANDARD_CRYSTAL;
            default: m = cfw_pkg::CFW_LOW_POWER_CRYSTAL;
        endcase
        return m;
    endfunction

    assign word_view = fuse_q | cfw_pkg::UNIMPL_MASK;

    always_comb begin
        rd_nxt = word_view;
        set_nxt.low_voltage_prog_enable = word_view[cfw_pkg::BIT_LVP];
        set_nxt.brownout_reset_en = word_view[cfw_pkg::BIT_BOR];
        set_nxt.watchdog_timer_en = word_view[cfw_pkg::BIT_WDT];
        set_nxt.powerup_timer_en = ~word_view[cfw_pkg::BIT_POWERUP_TIMER];
        set_nxt.data_memory_protect_on = ~word_view[cfw_pkg::BIT_DMP];
        set_nxt.program_memory_protect_on = ~word_view[cfw_pkg::BIT_PMP];
        set_nxt.osc_mode = osc_decode(word_view[cfw_pkg::BIT_OSC_HI:cfw_pkg::BIT_OSC_LO]);
    end

    assign protect_any = set_r.data_memory_protect_on | set_r.program_memory_protect_on;

    always_comb begin
        // Protected locations read all zeros
        mrd_nxt = protect_any ? 14'h0000 : mem_rd_raw;
    end

    // Settings registered so downstream logic sees a glitch-free value
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            set_r <= '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0,
                       cfw_pkg::CFW_RESISTOR_CAPACITOR_OSC};
            rd_r <= cfw_pkg::ERASED_WORD;
            mrd_r <= 14'h0000;
        end else if (clk_en) begin
            set_r <= set_nxt;
            rd_r <= rd_nxt;
            mrd_r <= mrd_nxt;
        end
    end

    assign settings = set_r;
    assign config_rd_data = rd_r;
    assign mem_rd_data = mrd_r;

    // Pin function follows the decoded low-voltage enable
    assign prog_mode = high_voltage_entry |
        (set_r.low_voltage_prog_enable & shared_port_pin_three_in);
    assign pin_three_to_port = ~set_r.low_voltage_prog_enable;
    assign shared_port_pin_three_oe = pin_three_to_port & port_pin_three_oe;
    assign shared_port_pin_three_out = pin_three_to_port & port_pin_three_out;
    assign bulk_erase_data_go = bulk_erase_data_req & ~set_r.data_memory_protect_on;
    assign mem_wr_go = mem_wr_req & ~protect_any;

    // Pin function checks
    lvp_entry_a: assert property (@(posedge clk) disable iff (!arst_n)
        set_r.low_voltage_prog_enable && shared_port_pin_three_in |-> prog_mode)
        else $error("low-voltage entry not honoured");
    lvp_pin_a: assert property (@(posedge clk) disable iff (!arst_n)
        set_r.low_voltage_prog_enable |->
            !shared_port_pin_three_oe && !shared_port_pin_three_out && !pin_three_to_port)
        else $error("port drove the entry pin");
    lvp_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en |=> set_r.low_voltage_prog_enable == $past(fuse_q[cfw_pkg::BIT_LVP]))
        else $error("low-voltage enable mismatch");
    hv_only_a: assert property (@(posedge clk) disable iff (!arst_n)
        !set_r.low_voltage_prog_enable |-> prog_mode == high_voltage_entry
            && !(shared_port_pin_three_oe ^ port_pin_three_oe))
        else $error("pin not plain I/O with entry disabled");
    pin_out_a: assert property (@(posedge clk) disable iff (!arst_n)
        !set_r.low_voltage_prog_enable |-> shared_port_pin_three_out == port_pin_three_out)
        else $error("port output not passed to pin");
    hv_entry_a: assert property (@(posedge clk) disable iff (!arst_n)
        high_voltage_entry |-> prog_mode)
        else $error("high-voltage entry not honoured");

    // Decode checks, one cycle behind the fuse cells
    bor_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en |=> set_r.brownout_reset_en == $past(word_view[cfw_pkg::BIT_BOR]))
        else $error("brown-out enable mismatch");
    wdt_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en |=> set_r.watchdog_timer_en == $past(fuse_q[cfw_pkg::BIT_WDT]))
        else $error("watchdog enable mismatch");
    osc_map_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && fuse_q[cfw_pkg::BIT_OSC_HI:cfw_pkg::BIT_OSC_LO] == cfw_pkg::OSC_HS |=>
            set_r.osc_mode == cfw_pkg::CFW_HIGH_SPEED_CRYSTAL)
        else $error("oscillator decode wrong");
    osc_rc_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && fuse_q[cfw_pkg::BIT_OSC_HI:cfw_pkg::BIT_OSC_LO] == cfw_pkg::OSC_RC |=>
            set_r.osc_mode == cfw_pkg::CFW_RESISTOR_CAPACITOR_OSC)
        else $error("resistor-capacitor decode wrong");
    osc_xt_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && fuse_q[cfw_pkg::BIT_OSC_HI:cfw_pkg::BIT_OSC_LO] == cfw_pkg::OSC_XT |=>
            set_r.osc_mode == cfw_pkg::CFW_STANDARD_CRYSTAL)
        else $error("standard crystal decode wrong");
    osc_lp_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && fuse_q[cfw_pkg::BIT_OSC_HI:cfw_pkg::BIT_OSC_LO] == cfw_pkg::OSC_LP |=>
            set_r.osc_mode == cfw_pkg::CFW_LOW_POWER_CRYSTAL)
        else $error("low-power crystal decode wrong");
    osc_onehot_a: assert property (@(posedge clk) disable iff (!arst_n)
        $onehot(set_r.osc_mode))
        else $error("oscillator mode not one-hot");
    unimpl_one_a: assert property (@(posedge clk) disable iff (!arst_n)
        (config_rd_data & cfw_pkg::UNIMPL_MASK) == cfw_pkg::UNIMPL_MASK)
        else $error("unimplemented bit read zero");
    powerup_timer_low_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en |=> set_r.powerup_timer_en != $past(fuse_q[cfw_pkg::BIT_POWERUP_TIMER]))
        else $error("power-up timer polarity wrong");

    // Each read-back bit is its fuse cell, or one where nothing is built
    for (genvar b = 0; b < cfw_pkg::WORD_W; b++) begin : g_view
        bit_view_a: assert property (@(posedge clk) disable iff (!arst_n)
            clk_en |=> config_rd_data[b] == ($past(fuse_q[b]) | cfw_pkg::UNIMPL_MASK[b]))
            else $error("read-back bit wrong");
    end

    // Protection checks
    dmp_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en |=> set_r.data_memory_protect_on != $past(fuse_q[cfw_pkg::BIT_DMP]))
        else $error("data protect decode wrong");
    bulk_block_a: assert property (@(posedge clk) disable iff (!arst_n)
        set_r.data_memory_protect_on |-> !bulk_erase_data_go)
        else $error("bulk data erase not blocked");
    bulk_pass_a: assert property (@(posedge clk) disable iff (!arst_n)
        !set_r.data_memory_protect_on |-> bulk_erase_data_go == bulk_erase_data_req)
        else $error("bulk data erase lost");
    pmp_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en |=> set_r.program_memory_protect_on != $past(fuse_q[cfw_pkg::BIT_PMP]))
        else $error("program protect decode wrong");
    protect_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && protect_any |=> mem_rd_data == 14'h0000 && !$past(mem_wr_go))
        else $error("protected memory exposed");
    wr_block_a: assert property (@(posedge clk) disable iff (!arst_n)
        protect_any |-> !mem_wr_go)
        else $error("protected memory write passed");
    rd_pass_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && !protect_any |=> mem_rd_data == $past(mem_rd_raw))
        else $error("open memory read wrong");
    config_open_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && protect_any && prog.wr && !chip_erase |=>
            fuse_q == ($past(fuse_q) & $past(prog.data)))
        else $error("config word refused under protection");

    // Clock enable low freezes every register of the block
    freeze_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        !clk_en |=> $stable(set_r) && $stable(rd_r) && $stable(mrd_r) && $stable(fuse_q))
        else $error("state moved with clock enable low");

    lvp_cov_c: cover property (@(posedge clk) disable iff (!arst_n)
        prog_mode && !high_voltage_entry);
    prot_cov_c: cover property (@(posedge clk) disable iff (!arst_n)
        set_r.program_memory_protect_on);
    erase_cov_c: cover property (@(posedge clk) disable iff (!arst_n)
        chip_erase ##1 !protect_any);
    hv_cov_c: cover property (@(posedge clk) disable iff (!arst_n)
        !set_r.low_voltage_prog_enable && high_voltage_entry);
    freeze_cov_c: cover property (@(posedge clk) disable iff (!arst_n)
        !clk_en ##1 clk_en);
endmodule

// file: testbench/cfwt_programmer.sv
// Programmer model that writes one fuse word per request
`timescale 1ns/1ps
module cfwt_programmer (
    input wire logic clk,
    input wire logic go,
    input wire logic [13:0] word,
    output cfw_pkg::cfw_prog_t prog
);
    logic go_s;
    logic [13:0] word_s;
    initial prog = '0;
    // A programmed word only ever clears fuse bits, so one strobe is enough
    // Request sampled on the edge so the bench's own drive never races it
    always @(posedge clk) begin
        go_s = go;
        word_s = word;
        #1;
        prog.wr = go_s;
        prog.data = word_s;
    end
endmodule

// file: testbench/test_cfw_decoder.sv
// Self-checking bench comparing the fuse word decoder with a behavioural model
`timescale 1ns/1ps
module test_cfw_decoder;
    logic clk = 0, arst_n = 0, go = 0, erase = 0, hv = 0, pin = 0, ce = 1;
    logic po = 0, poe = 0, ber = 0, mwr = 0, pm, p2p, spo, spoe, beg, mwg;
    logic [13:0] word = 14'h0000, raw = 14'h0000, cfg, mrd, w;
    cfw_pkg::cfw_prog_t prog;
    cfw_pkg::cfw_settings_t st, es;
    int failures = 0, checked = 0, cyc = 0;
    int unsigned seed = 23854, fw = 32'h0000_3FFF;
    always #5 clk = ~clk;
    cfwt_programmer u_cfwt_programmer (.clk(clk), .go(go), .word(word), .prog(prog));
    cfw_decoder u_cfw_decoder (.clk(clk), .arst_n(arst_n), .clk_en(ce), .prog(prog),
        .chip_erase(erase), .bulk_erase_data_req(ber), .high_voltage_entry(hv),
        .shared_port_pin_three_in(pin), .port_pin_three_out(po), .port_pin_three_oe(poe),
        .mem_wr_req(mwr), .mem_rd_raw(raw), .config_rd_data(cfg), .settings(st),
        .prog_mode(pm), .pin_three_to_port(p2p), .shared_port_pin_three_out(spo),
        .shared_port_pin_three_oe(spoe), .bulk_erase_data_go(beg), .mem_wr_go(mwg),
        .mem_rd_data(mrd));
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic cmp(input logic [13:0] got, input logic [13:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_set(input cfw_pkg::cfw_settings_t got, input cfw_pkg::cfw_settings_t exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t settings got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_all();
        logic prot;
        prot = !fw[8] || !fw[13];
        es.low_voltage_prog_enable = fw[7];
        es.brownout_reset_en = fw[6];
        es.watchdog_timer_en = fw[2];
        es.powerup_timer_en = !fw[3];
        es.data_memory_protect_on = !fw[8];
        es.program_memory_protect_on = !fw[13];
        es.osc_mode = cfw_pkg::cfw_osc_t'(4'h1 << fw[1:0]);
        cmp(cfg, fw[13:0] | cfw_pkg::UNIMPL_MASK, "config word");
        cmp_set(st, es);
        cmp(pm, hv | (fw[7] & pin), "prog mode");
        cmp(p2p, !fw[7], "pin to port");
        cmp(spoe, poe & !fw[7], "pin enable");
        cmp(spo, po & !fw[7], "pin out");
        cmp(beg, ber & fw[8], "bulk erase");
        cmp(mwg, mwr & !prot, "mem write");
        cmp(mrd, prot ? 14'h0000 : raw, "mem read");
    endtask
    // One erase or programming strobe, then time for both register stages
    task automatic strobe(input logic e, input logic [13:0] wv);
        @(posedge clk);
        #1;
        erase = e;
        go = !e;
        word = wv;
        @(posedge clk);
        #1;
        erase = 0;
        go = 0;
        repeat (4) @(posedge clk);
    endtask
    task automatic end_of_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Whole run needs under 200 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc > 400) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 arst_n = 1;
        repeat (3) @(posedge clk);
        #1 check_all();
        for (int k = 0; k < 24; k++) begin
            w = 14'(rnd());
            w[1:0] = 2'(k);
            {hv, pin, po, poe, ber, mwr} = 6'(rnd());
            raw = 14'(rnd());
            // Fuses only clear until a chip erase restores them
            if (k % 6 == 0) fw = 32'h0000_3FFF;
            else fw = fw & w;
            strobe(k % 6 == 0, w);
            #1 check_all();
            $display("test %0d done", k);
        end
        // Erase, then a strobe with the clock enable low must be lost
        fw = 32'h0000_3FFF;
        strobe(1'h1, 14'h0000);
        #1 check_all();
        ce = 0;
        strobe(1'h0, 14'h0000);
        #1 check_all();
        ce = 1;
        repeat (4) @(posedge clk);
        #1 check_all();
        $display("test freeze done");
        // Every fuse programmed, then a reset in mid-run
        fw = 32'h0000_0000;
        strobe(1'h0, 14'h0000);
        #1 check_all();
        arst_n = 0;
        repeat (2) @(posedge clk);
        #1 arst_n = 1;
        fw = 32'h0000_3FFF;
        repeat (3) @(posedge clk);
        #1 check_all();
        $display("test reset done");
        end_of_test();
    end
endmodule
